//--- verilog/gsmc_pin_config.sv
`timescale 1ns/10ps
module gsmc_pin_config
	import gsmc_pkg::*;
#(
	parameter int DELAY_W = 8
)
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	output logic [15:0] regRdata,
	input wire logic [DELAY_W-1:0] settleDelay,
	input wire logic alternateHoldMode,
	input wire logic [4:0] enabledChannels,
	input wire logic [3:0] inputPairSel,
	input wire logic channelSwitch,
	input wire logic statusErrors,
	input wire logic holdPin,
	input wire logic faultPinIn,
	output logic faultPinOut,
	output logic faultPinOeN,
	output logic converterReset,
	output logic conversionStart,
	output logic [3:0] muxSelect,
	output logic [3:0] muxSelectOeN,
	output logic [3:0] analogPairSel,
	output logic auxOutputsEnable,
	output logic converterError
);
	if (DELAY_W < 1 || DELAY_W > 16)
	begin : g_bad_delay_w
		$error("DELAY_W out of range");
	end

	logic [15:0] cfg_reg;
	logic [DELAY_W-1:0] delayCnt_reg;
	logic [3:0] chanIdx_reg;
	logic [1:0] holdSync_reg;
	logic [1:0] faultSync_reg;
	logic holdPrev_reg;
	gsmc_state_t state_reg;
	gsmc_state_t state_next;
	gsmc_fault_t faultMode;
	logic holdLevel;
	logic altActive;
	logic holdRise;

	// Register address decode
	function automatic logic cfgHit(input logic [7:0] addr);
		return addr == PIN_CFG_ADDR;
	endfunction : cfgHit

	assign faultMode = gsmc_fault_t'(cfg_reg[FAULT_MODE_HI:FAULT_MODE_LO]);
	assign holdLevel = holdSync_reg[1];
	assign altActive = cfg_reg[HOLD_EN_BIT] && alternateHoldMode && (enabledChannels > 5'h01);
	assign holdRise = holdLevel && !holdPrev_reg;

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			holdSync_reg <= 2'h3;
			faultSync_reg <= 2'h3;
			holdPrev_reg <= 1'b1;
		end
		else
		begin
			holdSync_reg <= {holdSync_reg[0], holdPin};
			faultSync_reg <= {faultSync_reg[0], faultPinIn};
			holdPrev_reg <= holdLevel;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			cfg_reg <= PIN_CFG_RESET;
		else if (regWrite && cfgHit(regAddr))
		begin
			cfg_reg[15:14] <= 2'h0;
			cfg_reg[13:9] <= regWdata[13:9] & PIN_CFG_WMASK[13:9];
			cfg_reg[FAULT_LEVEL_BIT] <= regWdata[FAULT_LEVEL_BIT];
			cfg_reg[7:0] <= regWdata[7:0];
		end
		else if (faultMode == GSMC_FAULT_IN)
			cfg_reg[FAULT_LEVEL_BIT] <= faultSync_reg[1];
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			regRdata <= 16'h0000;
		else if (regRead && cfgHit(regAddr))
			regRdata <= {2'h0, cfg_reg[13:0]};
		else if (regRead)
			regRdata <= 16'h0000;
	end

	// Channel index, wraps at enabledChannels or at sixteen, whichever is fewer
	always_ff @(posedge ref_clk)
	begin
		if (srst || !cfg_reg[MUX_CTRL_BIT])
			chanIdx_reg <= 4'h0;
		else if (channelSwitch)
		begin
			if ({1'b0, chanIdx_reg} + 5'h01 >= enabledChannels
				|| {1'b0, chanIdx_reg} + 5'h01 >= 5'(MUX_CHANNELS))
				chanIdx_reg <= 4'h0;
			else
				chanIdx_reg <= chanIdx_reg + 4'h1;
		end
	end

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			GSMC_RUN:
			begin
				if (channelSwitch)
				begin
					if (altActive && !holdLevel)
						state_next = GSMC_BLOCKED;
					else
						state_next = GSMC_SETTLE;
				end
			end
			GSMC_SETTLE:
			begin
				if (delayCnt_reg == '0)
					state_next = GSMC_RUN;
			end
			GSMC_BLOCKED:
			begin
				if (holdRise || !altActive)
					state_next = GSMC_SETTLE;
			end
			default:
				state_next = GSMC_RUN;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			state_reg <= GSMC_RUN;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			delayCnt_reg <= '0;
		else if (state_next == GSMC_SETTLE && state_reg != GSMC_SETTLE)
			delayCnt_reg <= settleDelay;
		else if (state_reg == GSMC_SETTLE && delayCnt_reg != '0)
			delayCnt_reg <= delayCnt_reg - 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			conversionStart <= 1'b0;
			converterReset <= 1'b1;
		end
		else
		begin
			conversionStart <= (state_reg == GSMC_SETTLE) && (delayCnt_reg == '0);
			converterReset <= cfg_reg[HOLD_EN_BIT] && !altActive && !holdLevel;
		end
	end

	// Pins
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			muxSelect <= 4'h0;
			muxSelectOeN <= 4'hF;
			analogPairSel <= 4'h0;
			auxOutputsEnable <= 1'b0;
			faultPinOut <= 1'b1;
			faultPinOeN <= 1'b1;
			converterError <= 1'b0;
		end
		else
		begin
			muxSelect <= chanIdx_reg;
			muxSelectOeN <= cfg_reg[MUX_CTRL_BIT] ? 4'h0 : 4'hF;
			analogPairSel <= inputPairSel;
			auxOutputsEnable <= cfg_reg[AUX_EN_BIT];
			converterError <= statusErrors || (faultMode == GSMC_FAULT_IN && !faultSync_reg[1]);
			case (faultMode)
				GSMC_FAULT_OD:
				begin
					faultPinOut <= 1'b0;
					faultPinOeN <= !statusErrors;
				end
				GSMC_FAULT_GPO:
				begin
					faultPinOut <= cfg_reg[FAULT_LEVEL_BIT];
					faultPinOeN <= 1'b0;
				end
				default:
				begin
					faultPinOut <= 1'b1;
					faultPinOeN <= 1'b1;
				end
			endcase
		end
	end

	a_reset_value: assert property (@(posedge ref_clk) srst |=> cfg_reg == PIN_CFG_RESET)
		else $error("config reset value wrong");
	a_reserved_zero: assert property (@(posedge ref_clk) disable iff (srst)
		!$past(srst) && $past(regRead) && $past(regAddr) == PIN_CFG_ADDR
		|-> regRdata == {2'h0, $past(cfg_reg[13:0])})
		else $error("read data or reserved bits wrong");
	a_aux_enable: assert property (@(posedge ref_clk) disable iff (srst)
		##1 auxOutputsEnable == $past(cfg_reg[AUX_EN_BIT]))
		else $error("aux enable mismatch");
	a_mux_drive: assert property (@(posedge ref_clk) disable iff (srst)
		cfg_reg[MUX_CTRL_BIT] && $past(cfg_reg[MUX_CTRL_BIT]) |=> muxSelectOeN == 4'h0)
		else $error("mux selects not driven");
	a_hold_reset: assert property (@(posedge ref_clk) disable iff (srst)
		cfg_reg[HOLD_EN_BIT] && !altActive && !holdLevel |=> converterReset)
		else $error("hold low did not reset");
	a_alt_block: assert property (@(posedge ref_clk) disable iff (srst)
		state_reg == GSMC_RUN && channelSwitch && altActive && !holdLevel
		|=> state_reg == GSMC_BLOCKED ##1 !conversionStart)
		else $error("alternate hold did not block");
	a_alt_resume: assert property (@(posedge ref_clk) disable iff (srst)
		state_reg == GSMC_BLOCKED && holdRise |=> state_reg == GSMC_SETTLE)
		else $error("hold rise did not resume");
	a_fault_od: assert property (@(posedge ref_clk) disable iff (srst)
		faultMode == GSMC_FAULT_OD && $stable(faultMode) |=> faultPinOeN == !$past(statusErrors))
		else $error("fault output wrong");
	a_fault_in: assert property (@(posedge ref_clk) disable iff (srst)
		faultMode == GSMC_FAULT_IN && !faultSync_reg[1] |=> converterError)
		else $error("fault input not reported");
endmodule : gsmc_pin_config

//--- verilog/gsmc_pkg.sv
// Operation
// - Pin configuration register at address 06h, sixteen bits, resets to 0800h.
// - Bit 13 enables both auxiliary outputs two and three; resets to zero.
// - Bit 12 drives four general pins as external mux selects, following sequencing.
// - Per-channel analog input pin choice still applies during external mux control.
// - At most sixteen channels are sequenced automatically with external mux.
// - Programmable settling delay after mux switching, taken from mode register delay bits.
// - Bit 11 enables hold pin as sync input; resets to one.
// - Normal mode: low hold pin keeps converter and filter in reset.
// - Alternate hold mode applies only when more than one channel enabled.
// - Alternate mode: low hold at channel switch blocks next conversion, no reset.
// - Alternate mode: rising hold input starts the pending conversion.
// - Bits 10 to 9 select fault pin mode; reset zero disables pin.
// - Mode 01: fault pin is active-low input, inverted level ORed into error.
// - Mode 10: fault pin open-drain active-low output of ORed status errors.
// - Mode 11: fault pin is general output following fault pin level bit.
package gsmc_pkg;
	localparam logic [7:0] PIN_CFG_ADDR = 8'h06;
	localparam logic [15:0] PIN_CFG_RESET = 16'h0800;
	localparam int AUX_EN_BIT = 13;
	localparam int MUX_CTRL_BIT = 12;
	localparam int HOLD_EN_BIT = 11;
	localparam int FAULT_MODE_HI = 10;
	localparam int FAULT_MODE_LO = 9;
	localparam int FAULT_LEVEL_BIT = 8;
	localparam logic [15:0] PIN_CFG_WMASK = 16'h3FFF;
	localparam int MUX_CHANNELS = 16;
	typedef enum logic [1:0]
	{
		GSMC_FAULT_OFF = 2'h0,
		GSMC_FAULT_IN = 2'h1,
		GSMC_FAULT_OD = 2'h2,
		GSMC_FAULT_GPO = 2'h3
	} gsmc_fault_t;
	typedef enum logic [1:0]
	{
		GSMC_RUN = 2'h0,
		GSMC_SETTLE = 2'h1,
		GSMC_BLOCKED = 2'h3
	} gsmc_state_t;
endpackage : gsmc_pkg

//--- testbench/gsmc_far_side.sv
`timescale 1ns/10ps
module gsmc_far_side
(
	input wire logic [3:0] muxSelect,
	input wire logic [3:0] muxSelectOeN,
	input wire logic faultPinOut,
	input wire logic faultPinOeN,
	input wire logic extPullLow,
	output logic faultWire,
	output logic [3:0] muxLine
);
	// Pulled-up shared line, low when any party drives low
	assign faultWire = !extPullLow && (faultPinOeN || faultPinOut);
	// Released select lines show the inverse of the current muxSelect value
	assign muxLine = muxSelect ^ muxSelectOeN;
endmodule : gsmc_far_side

//--- testbench/gsmc_pin_config_tb.sv
`timescale 1ns/10ps
module gsmc_pin_config_tb;
	import gsmc_pkg::*;
	logic ref_clk = 1'h0, srst = 1'h1, regWrite = 1'h0, regRead = 1'h0;
	logic [7:0] regAddr = 8'h00, settleDelay = 8'h00;
	logic [15:0] regWdata = 16'h0000, regRdata;
	logic alternateHoldMode = 1'h0, channelSwitch = 1'h0, statusErrors = 1'h0;
	logic holdPin = 1'h1, extPullLow = 1'h0;
	logic [4:0] enabledChannels = 5'h10;
	logic [3:0] inputPairSel = 4'h0, muxSelect, muxSelectOeN, analogPairSel, muxLine;
	logic faultPinOut, faultPinOeN, converterReset, conversionStart;
	logic auxOutputsEnable, converterError, faultWire;
	logic [31:0] lfsr = 32'hC96F;
	int error_cnt = 0, check_count = 0, cyc = 0;
	gsmc_pin_config #(.DELAY_W(8)) dut (.ref_clk(ref_clk), .srst(srst),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata), .settleDelay(settleDelay), .alternateHoldMode(alternateHoldMode),
		.enabledChannels(enabledChannels), .inputPairSel(inputPairSel),
		.channelSwitch(channelSwitch), .statusErrors(statusErrors), .holdPin(holdPin),
		.faultPinIn(faultWire), .faultPinOut(faultPinOut), .faultPinOeN(faultPinOeN),
		.converterReset(converterReset), .conversionStart(conversionStart),
		.muxSelect(muxSelect), .muxSelectOeN(muxSelectOeN), .analogPairSel(analogPairSel),
		.auxOutputsEnable(auxOutputsEnable), .converterError(converterError));
	gsmc_far_side far (.muxSelect(muxSelect), .muxSelectOeN(muxSelectOeN),
		.faultPinOut(faultPinOut), .faultPinOeN(faultPinOeN), .extPullLow(extPullLow),
		.faultWire(faultWire), .muxLine(muxLine));
	initial
		forever #2.5 ref_clk = ~ref_clk;
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	function automatic logic [15:0] expCfg(input logic [15:0] d);
		logic [15:0] e;
		e = d & PIN_CFG_WMASK;
		if (e[10:9] == 2'h1)
			e[8] = 1'h1;
		return e;
	endfunction : expCfg
	function automatic logic expWire(input logic [15:0] d, input logic se);
		return d[10:9] == 2'h3 ? d[8] : (d[10:9] == 2'h2 ? !se : 1'h1);
	endfunction : expWire
	task automatic summarize();
		$display("Checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			summarize();
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regWrite <= 1'h1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWrite <= 1'h0;
		tick(1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		regRead <= 1'h1;
		regAddr <= a;
		@(posedge ref_clk);
		regRead <= 1'h0;
		#1 chk("regRdata", e, regRdata);
	endtask : rd
	task automatic cnt(output int n);
		n = 0;
		do
		begin
			tick(1);
			n++;
		end
		while (conversionStart !== 1'h1 && n < 40);
	endtask : cnt
	task automatic sw(output int n);
		@(posedge ref_clk);
		channelSwitch <= 1'h1;
		@(posedge ref_clk);
		channelSwitch <= 1'h0;
		cnt(n);
	endtask : sw
	initial
	begin
		int n;
		logic [15:0] d;
		repeat (5) @(posedge ref_clk);
		srst <= 1'h0;
		rd(8'h06, PIN_CFG_RESET);
		wr(8'h06, 16'hFFFF);
		rd(8'h06, 16'h3FFF);
		wr(8'h07, 16'h0000);
		rd(8'h06, 16'h3FFF);
		rd(8'h05, 16'h0000);
		wr(8'h06, 16'h0800);
		@(posedge ref_clk);
		holdPin <= 1'h0;
		tick(5);
		chk("rst", 16'h1, 16'(converterReset));
		@(posedge ref_clk);
		holdPin <= 1'h1;
		tick(5);
		chk("rst", 16'h0, 16'(converterReset));
		wr(8'h06, 16'h0A00);
		@(posedge ref_clk);
		extPullLow <= 1'h1;
		tick(5);
		chk("err", 16'h1, 16'(converterError));
		@(posedge ref_clk);
		extPullLow <= 1'h0;
		wr(8'h06, 16'h1800);
		for (int k = 1; k <= 17; k++)
		begin
			@(posedge ref_clk);
			settleDelay <= 8'(k);
			sw(n);
			chk("wait", 16'(k + 1), 16'(n));
			chk("mux", 16'(k % 16), 16'(muxLine));
		end
		@(posedge ref_clk);
		inputPairSel <= 4'h1;
		tick(3);
		chk("pair", 16'h1, 16'(analogPairSel));
		@(posedge ref_clk);
		settleDelay <= 8'h00;
		wr(8'h06, 16'h0800);
		@(posedge ref_clk);
		alternateHoldMode <= 1'h1;
		enabledChannels <= 5'h02;
		holdPin <= 1'h0;
		tick(5);
		chk("rst", 16'h0, 16'(converterReset));
		sw(n);
		chk("blocked", 16'h1, 16'(n == 40));
		@(posedge ref_clk);
		holdPin <= 1'h1;
		cnt(n);
		chk("resumed", 16'h1, 16'(n < 40));
		@(posedge ref_clk);
		enabledChannels <= 5'h01;
		holdPin <= 1'h0;
		tick(5);
		chk("rst", 16'h1, 16'(converterReset));
		@(posedge ref_clk);
		holdPin <= 1'h1;
		alternateHoldMode <= 1'h0;
		enabledChannels <= 5'h10;
		for (int i = 0; i < 12; i++)
		begin
			@(posedge ref_clk);
			lfsr = nxt(lfsr);
			d = lfsr[15:0];
			inputPairSel <= lfsr[19:16];
			statusErrors <= lfsr[20];
			wr(8'h06, d);
			tick(4);
			rd(8'h06, expCfg(d));
			chk("aux", 16'(d[13]), 16'(auxOutputsEnable));
			chk("wire", 16'(expWire(d, lfsr[20])), 16'(faultWire));
			chk("err", 16'(lfsr[20]), 16'(converterError));
			chk("pair", 16'(lfsr[19:16]), 16'(analogPairSel));
		end
		@(posedge ref_clk);
		srst <= 1'h1;
		tick(3);
		@(posedge ref_clk);
		srst <= 1'h0;
		rd(8'h06, PIN_CFG_RESET);
		chk("aux", 16'h0, 16'(auxOutputsEnable));
		summarize();
	end
endmodule : gsmc_pin_config_tb
